// *** rtl/rss_pkg.sv ***
// package: register map, field layout, defaults and bus carriers of the reset sequencer
package rss_pkg;
  // ----------------------------------------
  // register byte addresses
  // ----------------------------------------
  localparam logic [4:0] GCFG_ADDR = 5'h00;
  localparam logic [4:0] WUC_ADDR = 5'h04;
  localparam logic [4:0] PORT_ADDR = 5'h08;
  localparam logic [4:0] STAT_ADDR = 5'h0c;
  // ----------------------------------------
  // field positions
  // ----------------------------------------
  localparam int SOFT_RST_BIT = 0;
  localparam int LOCK_BIT = 1;
  localparam int DATA_LSB = 8;
  localparam int PORT_DATA_LSB = 8;
  // ----------------------------------------
  // reset values and counts
  // ----------------------------------------
  localparam logic [7:0] MAIN_CFG_DEF = 8'h00;
  localparam logic [7:0] WUC_DATA_DEF = 8'h00;
  localparam logic [3:0] MRS_DEF = 4'hf;
  localparam logic [7:0] PORT_DATA_DEF = 8'h00;
  localparam logic [4:0] SB_RST_CYCLES = 5'h11;
  localparam logic [31:0] RD_ZERO = 32'h0000_0000;
  // ----------------------------------------
  // bus carriers
  // ----------------------------------------
  typedef struct packed {
    logic read;
    logic write;
    logic [4:0] address;
    logic [31:0] writedata;
  } rss_av_req_t;
  typedef struct packed {
    logic [31:0] readdata;
    logic waitrequest;
  } rss_av_rsp_t;
endpackage : rss_pkg

// *** rtl/rss_reset_sequencer.sv ***
// reset source sequencer: standby, main, hardware and software resets with register port
// What this block does
// - standby reset lasts 17 slow clock cycles or until host reset released
// - slow clock cycles are counted only once the slow clock toggles
// - standby reset clears locks, loads standby defaults, sets standby mux defaults
// - standby reset also runs main reset actions when main supply is good
// - main power-up reset lasts from main supply on until host reset released
// - bus writes during internal reset time are dropped; reads and the handshake still complete
// - main reset floats straps, enables pull-ups, samples them, then hardware reset
// - host reset pin causes hardware reset only while main supply is good
// - buffered reset outputs follow the host reset pin, even with main off
// - hardware reset clears locks, sets main mux defaults, then software reset
// - software reset is requested by writing the soft reset bit
// - software reset loads unlocked main defaults and resets legacy devices
// - software reset reloads unlocked port bits only where reload select is 1
// - standby state reset only by standby reset, except port bits with reload select 1, which main resets also reload; main state by any main reset
// - bus side and fast legacy side each get their own reset
// - slow clock is ignored until slow clock valid is high
//
// Chosen here: the Avalon-MM slave port and the placing of the registers.
`timescale 1ns/10ps
module rss_reset_sequencer #(
  parameter int NPORT = 4,
  parameter int STRAP_W = 3
) (
  input wire logic core_clk,
  input wire logic rst_b,
  input wire rss_pkg::rss_av_req_t av_req,
  output rss_pkg::rss_av_rsp_t av_rsp,
  input wire logic host_reset_n,
  input wire logic main_supply_good,
  input wire logic slow_clk_in,
  input wire logic slow_clock_valid,
  input wire logic [STRAP_W-1:0] strap_in,
  output logic [STRAP_W-1:0] strap_out,
  output logic [STRAP_W-1:0] strap_oe,
  output logic strap_pullup_en,
  output logic buf_reset_n,
  output logic bus_ignore,
  output logic lpc_domain_rst_n,
  output logic fast_domain_rst_n,
  output logic legacy_rst,
  output logic sb_mux_default,
  output logic main_mux_default,
  output logic [STRAP_W-1:0] strap_value,
  output logic [7:0] main_cfg,
  output logic [7:0] wuc_data,
  output logic [NPORT-1:0] main_reload_select,
  output logic [2*NPORT-1:0] port_data
);
  localparam int SW = 4 + STRAP_W;
  // ----------------------------------------
  // input synchronisers
  // ----------------------------------------
  logic [SW-1:0] in_meta_reg;
  logic [SW-1:0] in_sync_reg;
  logic hrst_n_s;
  logic main_good_s;
  logic slow_clk_s;
  logic slow_valid_s;
  // every pin is asynchronous to core_clk; only the second stage is read
  always_ff @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      in_meta_reg <= '0;
      in_sync_reg <= '0;
    end
    else
    begin
      in_meta_reg <= {strap_in, slow_clock_valid, slow_clk_in, main_supply_good, host_reset_n};
      in_sync_reg <= in_meta_reg;
    end
  end
  assign hrst_n_s = in_sync_reg[0];
  assign main_good_s = in_sync_reg[1];
  assign slow_clk_s = in_sync_reg[2];
  assign slow_valid_s = in_sync_reg[3];

  // ----------------------------------------
  // standby power-up reset
  // ----------------------------------------
  logic slow_clk_d_reg;
  logic slow_rise;
  logic [4:0] slow_cnt_reg;
  logic sb_rst_reg;
  // a frozen slow clock gives no edges, so start-up delay adds to the interval
  assign slow_rise = slow_valid_s && slow_clk_s && !slow_clk_d_reg;
  always_ff @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      slow_clk_d_reg <= 1'b0;
      slow_cnt_reg <= 5'h00;
      sb_rst_reg <= 1'b1;
    end
    else
    begin
      slow_clk_d_reg <= slow_clk_s;
      if (sb_rst_reg && slow_rise)
        slow_cnt_reg <= slow_cnt_reg + 5'h01;
      if (slow_cnt_reg == rss_pkg::SB_RST_CYCLES || hrst_n_s)
        sb_rst_reg <= 1'b0;
    end
  end

  // ----------------------------------------
  // main power-up and hardware reset
  // ----------------------------------------
  logic main_good_d_reg;
  logic mpor_reg;
  logic hw_rst;
  logic mpor_set;
  // standby reset with main already good counts as a main power-up
  assign mpor_set = (main_good_s && !main_good_d_reg) || (sb_rst_reg && main_good_s);
  always_ff @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      main_good_d_reg <= 1'b0;
      mpor_reg <= 1'b0;
    end
    else
    begin
      main_good_d_reg <= main_good_s;
      if (mpor_set)
        mpor_reg <= 1'b1;
      else if (hrst_n_s || !main_good_s)
        mpor_reg <= 1'b0;
    end
  end
  // the host pin means nothing while main power is down
  assign hw_rst = mpor_reg || (main_good_s && !hrst_n_s);

  // ----------------------------------------
  // software reset request
  // ----------------------------------------
  logic wr_take;
  logic rd_take;
  logic wait_reg;
  logic soft_bit_reg;
  logic sw_rst_reg;
  logic main_rst;
  logic irst;
  // internal reset time: writes are dropped, reads still answer for the bus
  assign irst = sb_rst_reg || mpor_reg;
  assign wr_take = av_req.write && !wait_reg && !irst;
  assign rd_take = av_req.read && !wait_reg;
  always_ff @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      soft_bit_reg <= 1'b0;
      sw_rst_reg <= 1'b0;
    end
    else
    begin
      sw_rst_reg <= soft_bit_reg;
      if (wr_take && av_req.address == rss_pkg::GCFG_ADDR && av_req.writedata[rss_pkg::SOFT_RST_BIT])
        soft_bit_reg <= 1'b1;
      else if (sw_rst_reg)
        soft_bit_reg <= 1'b0;
    end
  end
  // hardware reset implies every software reset action
  assign main_rst = hw_rst || sw_rst_reg;

  // ----------------------------------------
  // lock bits and configuration state
  // ----------------------------------------
  logic cfg_lock_reg;
  logic wuc_lock_reg;
  logic gcfg_wr;
  logic wuc_wr;
  logic port_wr;
  assign gcfg_wr = wr_take && av_req.address == rss_pkg::GCFG_ADDR;
  assign wuc_wr = wr_take && av_req.address == rss_pkg::WUC_ADDR;
  assign port_wr = wr_take && av_req.address == rss_pkg::PORT_ADDR;
  // locks can only be set by software and cleared by reset
  always_ff @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      cfg_lock_reg <= 1'b0;
      wuc_lock_reg <= 1'b0;
    end
    else
    begin
      if (sb_rst_reg || hw_rst)
      begin
        cfg_lock_reg <= 1'b0;
        wuc_lock_reg <= 1'b0;
      end
      else
      begin
        if (gcfg_wr && av_req.writedata[rss_pkg::LOCK_BIT])
          cfg_lock_reg <= 1'b1;
        if (wuc_wr && av_req.writedata[rss_pkg::LOCK_BIT])
          wuc_lock_reg <= 1'b1;
      end
    end
  end

  // main-powered configuration, reloaded by any main reset when unlocked
  always_ff @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
      main_cfg <= rss_pkg::MAIN_CFG_DEF;
    else if (main_rst && !cfg_lock_reg)
      main_cfg <= rss_pkg::MAIN_CFG_DEF;
    else if (gcfg_wr && !cfg_lock_reg)
      main_cfg <= av_req.writedata[rss_pkg::DATA_LSB +: 8];
  end

  // wake-up data is standby powered: only standby reset restores it
  always_ff @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
      wuc_data <= rss_pkg::WUC_DATA_DEF;
    else if (sb_rst_reg)
      wuc_data <= rss_pkg::WUC_DATA_DEF;
    else if (wuc_wr && !wuc_lock_reg)
      wuc_data <= av_req.writedata[rss_pkg::DATA_LSB +: 8];
  end

  // reload select itself is untouched by the software reset
  always_ff @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
      main_reload_select <= rss_pkg::MRS_DEF;
    else if (sb_rst_reg)
      main_reload_select <= rss_pkg::MRS_DEF;
    else if (port_wr && !cfg_lock_reg)
      main_reload_select <= av_req.writedata[NPORT-1:0];
  end

  // ----------------------------------------
  // per-port standby data
  // ----------------------------------------
  genvar gp;
  generate
    for (gp = 0; gp < NPORT; gp++)
    begin : g_port
      // a port follows main resets only when its reload select is set
      always_ff @(posedge core_clk or negedge rst_b)
      begin
        if (!rst_b)
          port_data[2*gp +: 2] <= rss_pkg::PORT_DATA_DEF[2*gp +: 2];
        else if (sb_rst_reg)
          port_data[2*gp +: 2] <= rss_pkg::PORT_DATA_DEF[2*gp +: 2];
        else if (main_rst && !cfg_lock_reg && main_reload_select[gp])
          port_data[2*gp +: 2] <= rss_pkg::PORT_DATA_DEF[2*gp +: 2];
        else if (port_wr && !cfg_lock_reg)
          port_data[2*gp +: 2] <= av_req.writedata[rss_pkg::PORT_DATA_LSB + 2*gp +: 2];
      end
    end
  endgenerate

  // ----------------------------------------
  // straps, pin defaults and reset outputs
  // ----------------------------------------
  logic [1:0] lpc_rel_reg;
  logic [1:0] fast_rel_reg;
  // straps float with pull-ups while main reset runs, captured as it ends
  always_ff @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      strap_out <= '0;
      strap_oe <= '0;
      strap_pullup_en <= 1'b1;
      strap_value <= '0;
    end
    else
    begin
      strap_out <= '0;
      strap_oe <= '0;
      strap_pullup_en <= mpor_reg;
      if (mpor_reg)
        strap_value <= in_sync_reg[SW-1:4];
    end
  end

  // pin and domain reset outputs, all registered
  always_ff @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      buf_reset_n <= 1'b0;
      bus_ignore <= 1'b1;
      legacy_rst <= 1'b1;
      sb_mux_default <= 1'b1;
      main_mux_default <= 1'b1;
      lpc_rel_reg <= 2'b00;
      fast_rel_reg <= 2'b00;
    end
    else
    begin
      buf_reset_n <= hrst_n_s;
      bus_ignore <= irst;
      legacy_rst <= main_rst;
      sb_mux_default <= sb_rst_reg;
      main_mux_default <= hw_rst;
      // assert at once, release only after two clean stages
      lpc_rel_reg <= main_rst ? 2'b00 : {lpc_rel_reg[0], 1'b1};
      fast_rel_reg <= (main_rst || sb_rst_reg) ? 2'b00 : {fast_rel_reg[0], 1'b1};
    end
  end
  assign lpc_domain_rst_n = lpc_rel_reg[1];
  assign fast_domain_rst_n = fast_rel_reg[1];

  // ----------------------------------------
  // avalon slave: one wait cycle, then answer
  // ----------------------------------------
  logic [31:0] rd_next;
  // unmapped addresses read as zero and writes to them are dropped
  always_comb
  begin
    rd_next = rss_pkg::RD_ZERO;
    if (av_req.address == rss_pkg::GCFG_ADDR)
    begin
      rd_next[rss_pkg::SOFT_RST_BIT] = soft_bit_reg;
      rd_next[rss_pkg::LOCK_BIT] = cfg_lock_reg;
      rd_next[rss_pkg::DATA_LSB +: 8] = main_cfg;
    end
    else if (av_req.address == rss_pkg::WUC_ADDR)
    begin
      rd_next[rss_pkg::LOCK_BIT] = wuc_lock_reg;
      rd_next[rss_pkg::DATA_LSB +: 8] = wuc_data;
    end
    else if (av_req.address == rss_pkg::PORT_ADDR)
    begin
      rd_next[NPORT-1:0] = main_reload_select;
      rd_next[rss_pkg::PORT_DATA_LSB +: 2*NPORT] = port_data;
    end
    else if (av_req.address == rss_pkg::STAT_ADDR)
    begin
      rd_next[4:0] = {slow_valid_s, main_good_s, hw_rst, mpor_reg, sb_rst_reg};
      rd_next[5] = hrst_n_s;
      rd_next[rss_pkg::DATA_LSB +: STRAP_W] = strap_value;
    end
  end

  // waitrequest stays high except in the one answering cycle
  always_ff @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      wait_reg <= 1'b1;
      av_rsp <= '{readdata: rss_pkg::RD_ZERO, waitrequest: 1'b1};
    end
    else
    begin
      wait_reg <= !((av_req.read || av_req.write) && wait_reg);
      av_rsp.waitrequest <= !((av_req.read || av_req.write) && wait_reg);
      if (av_req.read && wait_reg)
        av_rsp.readdata <= rd_next;
    end
  end

  // ----------------------------------------
  // assertions
  // ----------------------------------------
  a_sb_rst_ends: assert property (@(posedge core_clk) disable iff (!rst_b)
    (sb_rst_reg && hrst_n_s) |=> !sb_rst_reg)
    else $error("standby reset outlived host reset release");
  a_sb_count_gate: assert property (@(posedge core_clk) disable iff (!rst_b)
    !slow_valid_s |=> $stable(slow_cnt_reg))
    else $error("slow count moved without valid slow clock");
  a_sb_clear_lock: assert property (@(posedge core_clk) disable iff (!rst_b)
    sb_rst_reg |=> !cfg_lock_reg && !wuc_lock_reg && wuc_data == rss_pkg::WUC_DATA_DEF)
    else $error("standby reset left lock or wake data");
  a_main_por_hold: assert property (@(posedge core_clk) disable iff (!rst_b)
    (mpor_reg && !hrst_n_s && main_good_s) |=> mpor_reg)
    else $error("main reset dropped while host reset low");
  a_bus_ignore: assert property (@(posedge core_clk) disable iff (!rst_b)
    (irst && av_req.write && !wait_reg && av_req.address == rss_pkg::GCFG_ADDR) |=> !soft_bit_reg)
    else $error("write accepted during internal reset time");
  a_hw_gate_main: assert property (@(posedge core_clk) disable iff (!rst_b)
    (!main_good_s && !mpor_reg) |-> !hw_rst)
    else $error("host pin acted with main power off");
  a_buf_follow: assert property (@(posedge core_clk) disable iff (!rst_b)
    ##1 buf_reset_n == $past(hrst_n_s))
    else $error("buffered reset does not follow host pin");
  a_sw_reload_sel: assert property (@(posedge core_clk) disable iff (!rst_b)
    (sw_rst_reg && !sb_rst_reg) |=> $stable(main_reload_select))
    else $error("software reset touched reload select");
  a_soft_clears: assert property (@(posedge core_clk) disable iff (!rst_b)
    $rose(soft_bit_reg) |=> sw_rst_reg ##1 !soft_bit_reg)
    else $error("soft reset bit did not clear itself");
  a_release_chain: assert property (@(posedge core_clk) disable iff (!rst_b)
    $fell(main_rst) |-> !lpc_domain_rst_n ##1 !lpc_domain_rst_n)
    else $error("bus domain released too early");
  a_bus_answer: assert property (@(posedge core_clk) disable iff (!rst_b)
    (av_req.read && av_rsp.waitrequest) |=> !av_rsp.waitrequest)
    else $error("read not answered in one cycle");
  c_sw_reset: cover property (@(posedge core_clk) disable iff (!rst_b) $rose(sw_rst_reg));
  c_sb_by_count: cover property (@(posedge core_clk) disable iff (!rst_b)
    sb_rst_reg && !hrst_n_s ##1 !sb_rst_reg);
  c_hw_reset: cover property (@(posedge core_clk) disable iff (!rst_b) $rose(hw_rst) && !mpor_reg);
  c_main_por: cover property (@(posedge core_clk) disable iff (!rst_b) $fell(mpor_reg));
endmodule : rss_reset_sequencer

// *** dv/rss_host_model.sv ***
// host chipset model: reset pin, supply good, slow clock and strap levels
`timescale 1ns/10ps
module rss_host_model #(
  parameter int HOLD = 64,
  parameter int SLOW_HALF = 4
) (
  input wire logic core_clk,
  input wire logic pin_low_req,
  input wire logic main_on,
  input wire logic slow_run,
  input wire logic [2:0] strap_set,
  output logic host_reset_n,
  output logic main_supply_good,
  output logic slow_clk_in,
  output logic slow_clock_valid,
  output logic [2:0] strap_in
);
  // ----------------------------------------
  // pin behaviour
  // ----------------------------------------
  int hold_cnt = 0;
  int half_cnt = 0;
  // standby is up from time zero, so the reset pin starts low after it
  initial
  begin
    host_reset_n = 1'b0;
    main_supply_good = 1'b0;
    slow_clk_in = 1'b0;
    slow_clock_valid = 1'b0;
    strap_in = 3'h0;
  end
  // reset pin hold; HOLD stands for the long minimum, shortened to keep the run brief
  always @(posedge core_clk)
  begin
    if (pin_low_req && host_reset_n) hold_cnt <= 0;
    else if (hold_cnt < HOLD) hold_cnt <= hold_cnt + 1;
    if (pin_low_req) host_reset_n <= 1'b0;
    else if (hold_cnt >= HOLD) host_reset_n <= 1'b1;
  end
  // slow clock stands low until it is valid, then toggles every SLOW_HALF cycles
  always @(posedge core_clk)
  begin
    slow_clock_valid <= slow_run;
    half_cnt <= slow_run ? half_cnt + 1 : 0;
    slow_clk_in <= slow_run && ((half_cnt / SLOW_HALF) % 2 == 1);
    main_supply_good <= main_on;
    strap_in <= strap_set;
  end
endmodule : rss_host_model

// *** dv/test_reset_source_sequencer.sv ***
// testbench: reset sources, register effects and bus gating of the reset sequencer
`timescale 1ns/10ps
module test_reset_source_sequencer;
  // ----------------------------------------
  // signals and instances
  // ----------------------------------------
  localparam int SH = 4;
  localparam int HOLD = 64;
  logic core_clk = 1'b0;
  logic rst_b = 1'b0;
  rss_pkg::rss_av_req_t av_req = '0;
  rss_pkg::rss_av_rsp_t av_rsp;
  logic pin_low_req = 1'b1;
  logic main_on = 1'b0;
  logic slow_run = 1'b0;
  logic [2:0] strap_set = 3'h0;
  logic host_reset_n, main_supply_good, slow_clk_in, slow_clock_valid;
  logic [2:0] strap_in, strap_out, strap_oe, strap_value;
  logic strap_pullup_en, buf_reset_n, bus_ignore, lpc_domain_rst_n, fast_domain_rst_n;
  logic legacy_rst, sb_mux_default, main_mux_default;
  logic [7:0] main_cfg, wuc_data, port_data;
  logic [3:0] main_reload_select;
  logic [31:0] rd;
  int fails = 0;
  int checks_done = 0;

  rss_reset_sequencer #(.NPORT(4), .STRAP_W(3)) dut (.core_clk(core_clk), .rst_b(rst_b),
    .av_req(av_req), .av_rsp(av_rsp), .host_reset_n(host_reset_n), .main_supply_good(main_supply_good),
    .slow_clk_in(slow_clk_in), .slow_clock_valid(slow_clock_valid), .strap_in(strap_in),
    .strap_out(strap_out), .strap_oe(strap_oe), .strap_pullup_en(strap_pullup_en),
    .buf_reset_n(buf_reset_n), .bus_ignore(bus_ignore), .lpc_domain_rst_n(lpc_domain_rst_n),
    .fast_domain_rst_n(fast_domain_rst_n), .legacy_rst(legacy_rst), .sb_mux_default(sb_mux_default),
    .main_mux_default(main_mux_default), .strap_value(strap_value), .main_cfg(main_cfg),
    .wuc_data(wuc_data), .main_reload_select(main_reload_select), .port_data(port_data));

  rss_host_model #(.HOLD(HOLD), .SLOW_HALF(SH)) host (.core_clk(core_clk), .pin_low_req(pin_low_req),
    .main_on(main_on), .slow_run(slow_run), .strap_set(strap_set), .host_reset_n(host_reset_n),
    .main_supply_good(main_supply_good), .slow_clk_in(slow_clk_in), .slow_clock_valid(slow_clock_valid),
    .strap_in(strap_in));

  // 40 mhz core clock
  initial
  begin
    forever #12.5 core_clk = ~core_clk;
  end

  task chk(input string what, input logic [15:0] exp, input logic [15:0] got);
  begin
    checks_done++;
    if (got !== exp)
    begin
      fails++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  end
  endtask : chk

  task chk_win(input string what, input int lo, input int hi, input int got);
  begin
    checks_done++;
    if (got < lo || got > hi)
    begin
      fails++;
      $display("[ERR] %s expected %0d..%0d seen %0d", what, lo, hi, got);
    end
  end
  endtask : chk_win

  task cyc(input int n);
    repeat (n) @(posedge core_clk);
  endtask : cyc

  task settle;
    @(negedge core_clk);
  endtask : settle

  // one bus cycle; request held until waitrequest is sampled low, bounded wait
  task av(input logic w, input logic [4:0] a, input logic [31:0] d);
    int n;
  begin
    n = 0;
    @(posedge core_clk);
    av_req <= '{read: !w, write: w, address: a, writedata: d};
    do
    begin
      @(posedge core_clk);
      n++;
    end
    while (av_rsp.waitrequest !== 1'b0 && n < 40);
    rd = av_rsp.readdata;
    av_req <= '0;
    if (n >= 40) chk("waitrequest", 16'h0, 16'h1);
  end
  endtask : av

  // count cycles until the internal reset time is over
  task wait_free(output int n);
  begin
    n = 0;
    while (bus_ignore !== 1'b0 && n < 400)
    begin
      @(negedge core_clk);
      n++;
    end
  end
  endtask : wait_free

  task t_standby;
    int n;
  begin
    settle;
    chk("bus_ignore", 16'h1, bus_ignore);
    chk("sb_mux_default", 16'h1, sb_mux_default);
    chk("reload_sel", 16'hf, main_reload_select);
    chk("buf_reset_n", 16'h0, buf_reset_n);
    cyc(100);
    settle;
    chk("bus_ignore held", 16'h1, bus_ignore);
    @(posedge core_clk);
    slow_run <= 1'b1;
    wait_free(n);
    chk_win("standby length", 16 * 2 * SH, 17 * 2 * SH + 20, n);
    settle;
    chk("main_mux_default", 16'h0, main_mux_default);
    chk("legacy_rst", 16'h0, legacy_rst);
    chk("buf_reset_n off", 16'h0, buf_reset_n);
    av(1'b0, rss_pkg::STAT_ADDR, 32'h0);
    chk("status", 16'h10, rd[15:0] & 16'h3f);
    $display("test standby done");
  end
  endtask : t_standby

  task t_main_por;
    int n;
  begin
    @(posedge core_clk);
    main_on <= 1'b1;
    strap_set <= 3'h5;
    // host model stage, two sync stages, one edge to set the main reset, one more to register outputs
    cyc(5);
    settle;
    chk("bus_ignore", 16'h1, bus_ignore);
    chk("strap_pullup_en", 16'h1, strap_pullup_en);
    chk("strap_oe", 16'h0, strap_oe);
    chk("strap_out", 16'h0, strap_out);
    chk("lpc_domain_rst_n", 16'h0, lpc_domain_rst_n);
    chk("main_mux_default", 16'h1, main_mux_default);
    chk("legacy_rst", 16'h1, legacy_rst);
    av(1'b1, rss_pkg::PORT_ADDR, 32'h0000_ff00);
    av(1'b1, rss_pkg::GCFG_ADDR, 32'h0000_0001);
    @(posedge core_clk);
    pin_low_req <= 1'b0;
    wait_free(n);
    chk_win("main por end", 1, 12, n);
    chk("lpc release lag", 16'h0, lpc_domain_rst_n);
    cyc(4);
    settle;
    chk("buf_reset_n", 16'h1, buf_reset_n);
    chk("strap_value", 16'h5, strap_value);
    chk("strap_pullup_en", 16'h0, strap_pullup_en);
    chk("lpc_domain_rst_n", 16'h1, lpc_domain_rst_n);
    chk("fast_domain_rst_n", 16'h1, fast_domain_rst_n);
    chk("port_data", 16'h0, port_data);
    $display("test main power-up done");
  end
  endtask : t_main_por

  task t_soft;
    logic seen;
  begin
    seen = 1'b0;
    av(1'b1, rss_pkg::GCFG_ADDR, 32'h0000_a500);
    av(1'b0, rss_pkg::GCFG_ADDR, 32'h0);
    chk("cfg readback", 16'ha500, rd[15:0]);
    av(1'b1, rss_pkg::PORT_ADDR, 32'h0000_ff05);
    av(1'b1, rss_pkg::WUC_ADDR, 32'h0000_3c00);
    av(1'b1, rss_pkg::GCFG_ADDR, 32'h0000_a501);
    repeat (6)
    begin
      settle;
      seen = seen | (legacy_rst === 1'b1);
    end
    chk("legacy pulse", 16'h1, seen);
    chk("main_cfg", 16'h0, main_cfg);
    chk("port_data", 16'hcc, port_data);
    chk("reload_sel", 16'h5, main_reload_select);
    chk("wuc_data", 16'h3c, wuc_data);
    av(1'b0, rss_pkg::GCFG_ADDR, 32'h0);
    chk("soft bit", 16'h0, rd[0]);
    $display("test soft reset done");
  end
  endtask : t_soft

  task t_hw;
  begin
    av(1'b1, rss_pkg::GCFG_ADDR, 32'h0000_5a02);
    av(1'b0, rss_pkg::GCFG_ADDR, 32'h0);
    chk("lock set", 16'h5a02, rd[15:0]);
    av(1'b1, rss_pkg::PORT_ADDR, 32'h0000_000f);
    av(1'b0, rss_pkg::PORT_ADDR, 32'h0);
    chk("locked port", 16'h5, rd[3:0]);
    @(posedge core_clk);
    pin_low_req <= 1'b1;
    cyc(6);
    settle;
    chk("main_mux_default", 16'h1, main_mux_default);
    chk("buf_reset_n", 16'h0, buf_reset_n);
    @(posedge core_clk);
    pin_low_req <= 1'b0;
    cyc(HOLD + 10);
    av(1'b0, rss_pkg::GCFG_ADDR, 32'h0);
    chk("cfg after hw", 16'h0, rd[15:0]);
    chk("wuc_data", 16'h3c, wuc_data);
    av(1'b0, 5'h10, 32'h0);
    chk("unmapped", 16'h0, rd[15:0]);
    av(1'b0, rss_pkg::STAT_ADDR, 32'h0);
    chk("status", 16'h38, rd[15:0] & 16'h3f);
    $display("test hardware reset done");
  end
  endtask : t_hw

  task t_sb_main;
    int n;
  begin
    @(posedge core_clk);
    strap_set <= 3'h2;
    pin_low_req <= 1'b1;
    rst_b <= 1'b0;
    cyc(3);
    rst_b <= 1'b1;
    // synced main good needs two edges, then the main reset and its pull-up output
    cyc(4);
    settle;
    chk("strap_pullup_en", 16'h1, strap_pullup_en);
    @(posedge core_clk);
    pin_low_req <= 1'b0;
    wait_free(n);
    cyc(4);
    settle;
    chk("strap_value", 16'h2, strap_value);
    chk("wuc_data", 16'h0, wuc_data);
    chk("reload_sel", 16'hf, main_reload_select);
    chk("port_data", 16'h0, port_data);
    $display("test standby with main done");
  end
  endtask : t_sb_main

  task close_out;
  begin
    $display("checks %0d mismatches %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  end
  endtask : close_out

  // main sequence
  initial
  begin
    cyc(10);
    rst_b <= 1'b1;
    t_standby;
    t_main_por;
    t_soft;
    t_hw;
    t_sb_main;
    close_out;
  end

  // watchdog: the whole run needs well under 2000 cycles
  initial
  begin
    #500000;
    fails++;
    close_out;
  end
endmodule : test_reset_source_sequencer
